// [rtl/nvb_ctrl.sv]
// How it works
// RL1 - 64 bytes, reached only through registers
// RL2 - each access moves one byte
// RL3 - address holds six bits, upper read zero
// RL4 - control at 40H, bank 1, indirect only
// RL5 - reset clears control, bits 7-4 zero
// RL6 - write starts only with permission already set
// RL7 - hardware clears write-start on completion
// RL8 - read starts only with permission already set
// RL9 - read end clears start, loads data
// RL10 - read data held until next operation
// RL11 - write length set by asynchronous timer
// RL12 - software never sets starts together
// RL13 - software read sequence then polls
// RL14 - software write sequence then waits
// RL15 - software sets start right after permission
// RL16 - write end sets both interrupt flags
// RL17 - vector needs all enables, stack free
// RL18 - service clears only multi-function flag
// RL19 - software avoids sleep during cycles
// RL20 - software keeps permission off normally
// RL21 - bank pointer resets to zero, watchdog exception
// RL22 - timer ticks counted after synchronisation
`include "nvb_defines.svh"
`timescale 1ns/1ps
`default_nettype none

module nvb_ctrl import nvb_pkg::*; #(
  parameter int WR_TICKS = `NVB_WR_TICKS,
  parameter int READ_CYCLES = `NVB_READ_CYCLES
) (
  // clock and reset
  input wire logic clock,
  input wire logic sys_rst,
  input wire logic wdt_pd_rst,
  // register access from the core
  input wire nvb_sfr_t sfr,
  output logic [7:0] sfr_rdata_q,
  // write timer from the slow oscillator
  input wire logic nv_timer_clk,
  // interrupt controller side
  input wire logic global_irq_enable,
  input wire logic stack_full,
  input wire logic irq_ack,
  output logic irq_req_q,
  output logic nv_write_irq_flag_q,
  output logic mf_irq_flag_q
);

  default clocking cb @(posedge clock); endclocking
  default disable iff (sys_rst);

  // ----------------------------------------
  // state
  // ----------------------------------------
  nvb_state_t state_q, state_d;
  nvb_ctrl_t ctrl_q, ctrl_d;
  logic [5:0] addr_q;
  logic [7:0] data_q, data_d;
  logic [1:0] bank_q;
  logic wien_q, mien_q;
  logic [7:0] cnt_q, cnt_d;
  logic tsync1_q, tsync2_q, tsync3_q, tlevel_q, tprev_q;
  logic [7:0] mem_rdata;

  // ----------------------------------------
  // decode
  // ----------------------------------------
  wire [1:0] eff_bank = sfr.indirect ? bank_q : 2'h0;
  // bank select only gates the control register; others live in every bank
  wire hit_ctrl = (sfr.addr == `NVB_OFS_CTRL) && (eff_bank == `NVB_BANK_CTRL); // [RL4]
  wire hit_addr = sfr.addr == `NVB_OFS_ADDR;
  wire hit_data = sfr.addr == `NVB_OFS_DATA;
  wire hit_bank = sfr.addr == `NVB_OFS_BANK;
  wire hit_intc = sfr.addr == `NVB_OFS_INTC;
  wire wr_ctrl = sfr.wr && hit_ctrl;
  wire idle = state_q == NVB_IDLE;

  // permission must already be set before this write; write start has priority
  wire go_write = wr_ctrl && idle && ctrl_q.write_permit && sfr.wdata[`NVB_BIT_WR]; // [RL6] [RL12]
  wire go_read = wr_ctrl && idle && ctrl_q.read_permit && sfr.wdata[`NVB_BIT_RD]
    && !go_write; // [RL8]

  // ----------------------------------------
  // timer tick: three stages, change taken once stages two and three agree
  // ----------------------------------------
  wire tick = tlevel_q && !tprev_q; // [RL22]

  always_ff @(posedge clock) begin
    tsync1_q <= nv_timer_clk;
    tsync2_q <= tsync1_q;
    tsync3_q <= tsync2_q;
    if (tsync2_q == tsync3_q) begin
      tlevel_q <= tsync3_q;
    end
    tprev_q <= tlevel_q;
  end

  // ----------------------------------------
  // sequencer
  // ----------------------------------------
  wire read_end = (state_q == NVB_READ) && (cnt_q == 8'(READ_CYCLES - 1));
  // write length counts slow ticks, so it varies in system cycles
  wire write_end = (state_q == NVB_WRITE) && tick && (cnt_q == 8'(WR_TICKS - 1)); // [RL11]

  always_comb begin
    state_d = state_q;
    cnt_d = cnt_q;
    unique case (state_q)
      NVB_IDLE: begin
        cnt_d = 8'h00;
        state_d = go_write ? NVB_WRITE : (go_read ? NVB_READ : NVB_IDLE);
      end
      NVB_READ: begin
        cnt_d = cnt_q + 8'h01;
        state_d = read_end ? NVB_IDLE : NVB_READ;
      end
      NVB_WRITE: begin
        cnt_d = tick ? cnt_q + 8'h01 : cnt_q;
        state_d = write_end ? NVB_IDLE : NVB_WRITE;
      end
      default: state_d = NVB_IDLE;
    endcase
  end

  // ----------------------------------------
  // control register
  // ----------------------------------------
  always_comb begin
    ctrl_d = ctrl_q;
    if (wr_ctrl) begin
      ctrl_d.write_permit = sfr.wdata[`NVB_BIT_WRITE_PERMIT];
      ctrl_d.read_permit = sfr.wdata[`NVB_BIT_READ_PERMIT];
    end
    // software cannot clear a start bit; only completion does
    ctrl_d.write_start = (ctrl_q.write_start || go_write) && !write_end; // [RL7]
    ctrl_d.read_start = (ctrl_q.read_start || go_read) && !read_end; // [RL9]
  end

  // read result wins over a same-cycle software write
  always_comb begin
    data_d = data_q;
    if (sfr.wr && hit_data) begin
      data_d = sfr.wdata;
    end
    if (read_end) begin
      data_d = mem_rdata; // [RL9] [RL10]
    end
  end

  always_ff @(posedge clock) begin
    if (sys_rst) begin
      state_q <= NVB_IDLE;
      ctrl_q <= `NVB_CTRL_RST; // [RL5]
      cnt_q <= 8'h00;
      // data is cleared so the hold check never starts from an unknown value
      data_q <= 8'h00;
    end else begin
      state_q <= state_d;
      ctrl_q <= ctrl_d;
      cnt_q <= cnt_d;
      data_q <= data_d;
    end
  end

  // address is left unreset, as the core treats it as undefined
  always_ff @(posedge clock) begin
    if (sfr.wr && hit_addr) begin
      addr_q <= sfr.wdata[5:0]; // [RL3]
    end
  end

  // a watchdog reset out of power-down keeps the bank selection
  always_ff @(posedge clock) begin
    if (sys_rst && !wdt_pd_rst) begin
      bank_q <= `NVB_BANK_RST; // [RL21]
    end else if (sfr.wr && hit_bank) begin
      bank_q <= sfr.wdata[1:0];
    end
  end

  // ----------------------------------------
  // store: byte written at cycle start, read data latched at read end
  // ----------------------------------------
  nvb_store #(.DEPTH(`NVB_DEPTH), .AW(6)) u_store (
    .clock(clock),
    .we(go_write), // [RL2]
    .addr(addr_q), // [RL1]
    .wdata(data_q),
    .rdata_q(mem_rdata)
  );

  // ----------------------------------------
  // interrupt flags
  // ----------------------------------------
  wire clr_wflag = sfr.wr && hit_intc && !sfr.wdata[`NVB_BIT_WFLAG];
  wire clr_mflag = (sfr.wr && hit_intc && !sfr.wdata[`NVB_BIT_MFLAG]) || irq_ack; // [RL18]

  always_ff @(posedge clock) begin
    if (sys_rst) begin
      nv_write_irq_flag_q <= 1'b0;
      mf_irq_flag_q <= 1'b0;
      wien_q <= 1'b0;
      mien_q <= 1'b0;
      irq_req_q <= 1'b0;
    end else begin
      // set wins over clear
      nv_write_irq_flag_q <= write_end || (nv_write_irq_flag_q && !clr_wflag); // [RL16]
      mf_irq_flag_q <= write_end || (mf_irq_flag_q && !clr_mflag); // [RL16]
      if (sfr.wr && hit_intc) begin
        wien_q <= sfr.wdata[`NVB_BIT_WIEN];
        mien_q <= sfr.wdata[`NVB_BIT_MIEN];
      end
      irq_req_q <= global_irq_enable && wien_q && mien_q && mf_irq_flag_q
        && nv_write_irq_flag_q && !stack_full && !irq_ack; // [RL17]
    end
  end

  // ----------------------------------------
  // read back
  // ----------------------------------------
  wire [7:0] rd_mux =
    hit_ctrl ? {4'h0, ctrl_q} : // [RL5]
    hit_addr ? {2'h0, addr_q} : // [RL3]
    hit_data ? data_q :
    hit_bank ? {6'h00, bank_q} :
    hit_intc ? {4'h0, mien_q, wien_q, mf_irq_flag_q, nv_write_irq_flag_q} : 8'h00;

  always_ff @(posedge clock) begin
    if (sys_rst) begin
      sfr_rdata_q <= 8'h00;
    end else if (sfr.rd) begin
      sfr_rdata_q <= rd_mux;
    end
  end

  // ----------------------------------------
  // checks
  // ----------------------------------------
  sequence s_read_go;
    go_read;
  endsequence
  sequence s_read_done;
    !ctrl_q.read_start && (state_q == NVB_IDLE);
  endsequence

  property p_addr_upper;
    sfr.rd && hit_addr |=> sfr_rdata_q[7:6] == 2'h0;
  endproperty
  a_addr_upper: assert property (p_addr_upper) else $error("address upper bits not zero"); // [RL3]
  property p_ctrl_upper;
    sfr.rd && hit_ctrl |=> sfr_rdata_q[7:4] == 4'h0;
  endproperty
  a_ctrl_upper: assert property (p_ctrl_upper) else $error("control upper bits not zero"); // [RL5]
  property p_wr_needs_permit;
    wr_ctrl && idle && !ctrl_q.write_permit |=> !ctrl_q.write_start;
  endproperty
  a_wr_needs_permit: assert property (p_wr_needs_permit) else $error("write began unpermitted"); // [RL6]
  property p_rd_needs_permit;
    wr_ctrl && idle && !ctrl_q.read_permit |=> !ctrl_q.read_start;
  endproperty
  a_rd_needs_permit: assert property (p_rd_needs_permit) else $error("read began unpermitted"); // [RL8]
  property p_read_ends;
    s_read_go |=> ctrl_q.read_start ##[1:4] s_read_done;
  endproperty
  a_read_ends: assert property (p_read_ends) else $error("read cycle did not end"); // [RL9]
  property p_write_flags;
    $fell(ctrl_q.write_start) |-> nv_write_irq_flag_q && mf_irq_flag_q;
  endproperty
  a_write_flags: assert property (p_write_flags) else $error("write end left flags clear"); // [RL16]
  property p_write_waits;
    go_write |=> ctrl_q.write_start [*2];
  endproperty
  a_write_waits: assert property (p_write_waits) else $error("write ended too early"); // [RL11]
  property p_irq_gate;
    irq_req_q |-> $past(global_irq_enable) && $past(wien_q) && $past(mien_q)
      && !$past(stack_full);
  endproperty
  a_irq_gate: assert property (p_irq_gate) else $error("vector request without enables"); // [RL17]
  property p_ack_keeps_flag;
    irq_ack && nv_write_irq_flag_q && !clr_wflag |=> nv_write_irq_flag_q && !irq_req_q;
  endproperty
  a_ack_keeps_flag: assert property (p_ack_keeps_flag) else $error("service cleared write flag"); // [RL18]
  property p_data_hold;
    idle && !(sfr.wr && hit_data) |=> $stable(data_q);
  endproperty
  a_data_hold: assert property (p_data_hold) else $error("data register changed"); // [RL10]
  property p_bank_reset;
    disable iff (1'b0) sys_rst && !wdt_pd_rst |=> bank_q == 2'h0;
  endproperty
  a_bank_reset: assert property (p_bank_reset) else $error("bank pointer not reset"); // [RL21]

endmodule // nvb_ctrl

`default_nettype wire

// [rtl/nvb_defines.svh]
`ifndef NVB_DEFINES_SVH
`define NVB_DEFINES_SVH

// ----------------------------------------
// register offsets
// ----------------------------------------
`define NVB_OFS_CTRL 8'h40
`define NVB_OFS_ADDR 8'h1E
`define NVB_OFS_DATA 8'h1F
`define NVB_OFS_BANK 8'h04
`define NVB_OFS_INTC 8'h20
`define NVB_BANK_CTRL 2'h1

// ----------------------------------------
// field positions
// ----------------------------------------
`define NVB_BIT_RD 0
`define NVB_BIT_READ_PERMIT 1
`define NVB_BIT_WR 2
`define NVB_BIT_WRITE_PERMIT 3
`define NVB_BIT_WFLAG 0
`define NVB_BIT_MFLAG 1
`define NVB_BIT_WIEN 2
`define NVB_BIT_MIEN 3

// ----------------------------------------
// reset values and timing
// ----------------------------------------
`define NVB_CTRL_RST 4'h0
`define NVB_BANK_RST 2'h0
`define NVB_READ_CYCLES 2
`define NVB_WR_TICKS 4
`define NVB_DEPTH 64

`endif

// [rtl/nvb_pkg.sv]
package nvb_pkg;

  typedef struct packed {
    logic write_permit;
    logic write_start;
    logic read_permit;
    logic read_start;
  } nvb_ctrl_t;

  typedef struct packed {
    logic wr;
    logic rd;
    logic indirect;
    logic [7:0] addr;
    logic [7:0] wdata;
  } nvb_sfr_t;

  typedef enum logic [1:0] {
    NVB_IDLE = 2'b00,
    NVB_READ = 2'b01,
    NVB_WRITE = 2'b10
  } nvb_state_t;

endpackage

// [rtl/nvb_store.sv]
`timescale 1ns/1ps
`default_nettype none

// ----------------------------------------
// byte store, registered read
// ----------------------------------------
module nvb_store #(
  parameter int DEPTH = 64,
  parameter int AW = 6
) (
  // clock
  input wire logic clock,
  // access
  input wire logic we,
  input wire logic [AW-1:0] addr,
  input wire logic [7:0] wdata,
  output logic [7:0] rdata_q
);

  logic [7:0] mem [DEPTH];

  always_ff @(posedge clock) begin
    if (we) begin
      mem[addr] <= wdata;
    end
    rdata_q <= mem[addr];
  end

endmodule // nvb_store

`default_nettype wire

// [tb/tb_nvb_ctrl.sv]
`timescale 1ns/1ps
`default_nettype none
`include "nvb_defines.svh"

module tb_nvb_ctrl import nvb_pkg::*; ;
  // ----------------------------------------
  // signals and design
  // ----------------------------------------
  logic clock = 1'b0;
  logic sys_rst = 1'b1;
  logic wdt_pd_rst = 1'b0;
  logic nv_timer_clk = 1'b0;
  logic global_irq_enable = 1'b0;
  logic stack_full = 1'b1;
  logic irq_ack = 1'b0;
  nvb_sfr_t sfr = '0;
  logic [7:0] sfr_rdata_q;
  logic irq_req_q;
  logic nv_write_irq_flag_q;
  logic mf_irq_flag_q;
  int num_errors = 0;
  int total_checks = 0;
  int cycles = 0;
  logic [7:0] v;
  logic [7:0] adr [3] = '{8'h00, 8'h15, 8'h3F};
  logic [7:0] dat [3] = '{8'hA5, 8'h3C, 8'h5A};

  nvb_ctrl #(.WR_TICKS(2), .READ_CYCLES(2)) nvb_ctrl_i (
    .clock(clock),
    .sys_rst(sys_rst),
    .wdt_pd_rst(wdt_pd_rst),
    .sfr(sfr),
    .sfr_rdata_q(sfr_rdata_q),
    .nv_timer_clk(nv_timer_clk),
    .global_irq_enable(global_irq_enable),
    .stack_full(stack_full),
    .irq_ack(irq_ack),
    .irq_req_q(irq_req_q),
    .nv_write_irq_flag_q(nv_write_irq_flag_q),
    .mf_irq_flag_q(mf_irq_flag_q)
  );

  initial begin
    forever #5 clock = ~clock;
  end

  // ends the run after 20000 cycles if the tests never finish
  always @(posedge clock) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      num_errors++;
      wrap_up();
    end
  end

  // ----------------------------------------
  // access tasks
  // ----------------------------------------
  task automatic check(input string what, input logic [7:0] exp, input logic [7:0] got);
    total_checks++;
    if (got !== exp) begin
      num_errors++;
      $display("unexpected %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic reg_wr(input logic ind, input logic [7:0] a, input logic [7:0] d);
    @(negedge clock);
    sfr.wr = 1'b1;
    sfr.indirect = ind;
    sfr.addr = a;
    sfr.wdata = d;
    @(negedge clock);
    sfr.wr = 1'b0;
  endtask

  task automatic reg_rd(input logic ind, input logic [7:0] a, output logic [7:0] d);
    @(negedge clock);
    sfr.rd = 1'b1;
    sfr.indirect = ind;
    sfr.addr = a;
    @(negedge clock);
    sfr.rd = 1'b0;
    d = sfr_rdata_q;
  endtask

  // control sits behind the indirect port, bank pointer must already be 1
  task automatic ctrl_rd(input logic [7:0] exp);
    reg_rd(1'b1, `NVB_OFS_CTRL, v);
    check("control", exp, v);
  endtask

  // the timer clock only moves while polling, so a running write stays visible
  task automatic wait_bit(input int b);
    for (int i = 0; i < 200; i++) begin
      nv_timer_clk = ~nv_timer_clk;
      reg_rd(1'b1, `NVB_OFS_CTRL, v);
      if (v[b] === 1'b0) break;
    end
    check("start bit", 8'h00, {7'h00, v[b]});
  endtask

  task automatic wrap_up();
    $display("checks %0d mismatches %0d", total_checks, num_errors);
    if (num_errors == 0 && total_checks > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask

  // ----------------------------------------
  // tests
  // ----------------------------------------
  initial begin
    repeat (16) @(posedge clock);
    @(negedge clock);
    sys_rst = 1'b0;
    reg_rd(1'b0, `NVB_OFS_BANK, v);
    check("bank", 8'h00, v);
    reg_wr(1'b0, `NVB_OFS_BANK, 8'h01);
    ctrl_rd(8'h00);
    $display("test reset done");

    reg_wr(1'b0, `NVB_OFS_ADDR, 8'hFF);
    reg_rd(1'b0, `NVB_OFS_ADDR, v);
    check("address", 8'h3F, v);
    reg_wr(1'b1, `NVB_OFS_CTRL, 8'h04);
    ctrl_rd(8'h00);
    reg_wr(1'b1, `NVB_OFS_CTRL, 8'h01);
    ctrl_rd(8'h00);
    reg_wr(1'b1, `NVB_OFS_CTRL, 8'h0A);
    ctrl_rd(8'h0A);
    reg_rd(1'b0, `NVB_OFS_CTRL, v);
    check("direct control", 8'h00, v);
    reg_wr(1'b1, `NVB_OFS_CTRL, 8'h00);
    $display("test refusals done");

    for (int k = 0; k < 3; k++) begin
      reg_wr(1'b0, `NVB_OFS_ADDR, adr[k]);
      reg_wr(1'b0, `NVB_OFS_DATA, dat[k]);
      reg_wr(1'b1, `NVB_OFS_CTRL, 8'h08);
      reg_wr(1'b1, `NVB_OFS_CTRL, 8'h0C);
      ctrl_rd(8'h0C);
      wait_bit(2);
      check("flags", 8'h03, {6'h00, mf_irq_flag_q, nv_write_irq_flag_q});
      global_irq_enable = 1'b1;
      reg_wr(1'b0, `NVB_OFS_INTC, 8'h0F);
      @(negedge clock);
      check("req while stack full", 8'h00, {7'h00, irq_req_q});
      stack_full = 1'b0;
      repeat (2) @(negedge clock);
      check("req", 8'h01, {7'h00, irq_req_q});
      irq_ack = 1'b1;
      @(negedge clock);
      irq_ack = 1'b0;
      repeat (2) @(negedge clock);
      check("flags after service", 8'h01, {6'h00, mf_irq_flag_q, nv_write_irq_flag_q});
      reg_wr(1'b0, `NVB_OFS_INTC, 8'h0C);
      @(negedge clock);
      check("write flag cleared", 8'h00, {7'h00, nv_write_irq_flag_q});
      global_irq_enable = 1'b0;
      stack_full = 1'b1;
      reg_wr(1'b1, `NVB_OFS_CTRL, 8'h00);
    end
    $display("test writes done");

    for (int k = 0; k < 3; k++) begin
      reg_wr(1'b1, `NVB_OFS_CTRL, 8'h02);
      reg_wr(1'b0, `NVB_OFS_ADDR, adr[k]);
      reg_wr(1'b1, `NVB_OFS_CTRL, 8'h03);
      wait_bit(0);
      reg_rd(1'b0, `NVB_OFS_DATA, v);
      check("read data", dat[k], v);
      reg_wr(1'b0, `NVB_OFS_ADDR, 8'h00);
      reg_rd(1'b0, `NVB_OFS_DATA, v);
      check("held data", dat[k], v);
      reg_wr(1'b1, `NVB_OFS_CTRL, 8'h00);
    end
    $display("test reads done");

    @(negedge clock);
    sys_rst = 1'b1;
    wdt_pd_rst = 1'b1;
    repeat (2) @(negedge clock);
    sys_rst = 1'b0;
    wdt_pd_rst = 1'b0;
    reg_rd(1'b0, `NVB_OFS_BANK, v);
    check("bank kept", 8'h01, v);
    ctrl_rd(8'h00);
    @(negedge clock);
    sys_rst = 1'b1;
    repeat (2) @(negedge clock);
    sys_rst = 1'b0;
    reg_rd(1'b0, `NVB_OFS_BANK, v);
    check("bank cleared", 8'h00, v);
    $display("test resets done");
    wrap_up();
  end
endmodule // tb_nvb_ctrl

`default_nettype wire
